// [dsd_decoder.sv]
// Data-space decoder with program-memory read window, core registers and PC.
// Assumes the core issues at most one read or write per cycle, and program
// memory, peripherals and EEPROM answer reads combinationally within a cycle.
//
// Overview of operation
// - Addresses 40h..7Fh read bytes from program memory.
// - Program address is window base above the low six address bits.
// - Window base keeps six bits 5..0; bits 7 and 6 unused.
// - Window base at C9h is write-only; reads of it return 00h.
// - Window base is not reset; software writes it before use.
// - Window moves over 000h..FFFh in 64-byte steps.
// - Program counter is twelve bits wide.
// - Return stack holds six twelve-bit entries.
// - Addresses 00h..3Fh go to the selected RAM or EEPROM bank.
// - Decode X, Y at 80h/81h, V, W at 82h/83h, A at FFh.
// - Sixty bytes of data RAM sit at 84h..BFh.
// - Decode port data, direction and option registers for ports A..C.
// - Decode converter, timer, auto-reload timer and watchdog registers.
// - Interrupt option, window base, bank select are write-only; EEPROM control at EAh.
// - Readout protection blocks external program-memory readout.
// - Bank bit 4 selects RAM page two, bit 0 EEPROM page zero.
// - Bank select is not reset; software writes it before use.
`timescale 1ns/1ps
module dsd_decoder (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  output logic [11:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [7:0] pmem_rdata,
  output logic [7:0] per_addr,
  output logic per_rd,
  output logic per_wr,
  output logic [7:0] per_wdata,
  input wire logic [7:0] per_rdata,
  output logic [5:0] ee_addr,
  output logic ee_rd,
  output logic ee_wr,
  output logic [7:0] ee_wdata,
  input wire logic [7:0] ee_rdata,
  input wire logic readout_protect,
  input wire logic ext_rd,
  input wire logic [11:0] ext_addr,
  output logic [7:0] ext_rdata,
  output logic ext_rvalid,
  input wire logic pc_inc,
  input wire logic pc_jump,
  input wire logic pc_call,
  input wire logic pc_ret,
  input wire logic [11:0] pc_target,
  output logic [11:0] program_counter,
  output logic stack_full
);

  // ****************************************************************
  // Reset release and address decode
  // ****************************************************************
  logic rst_meta_r;
  logic rst_n_s;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_r <= 1'b0;
      rst_n_s <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_s <= rst_meta_r;
    end
  end

  function automatic dsd_pkg::dsd_region_t decode(input logic [7:0] a, input logic [7:0] bsel);
    dsd_pkg::dsd_region_t r;
    r = dsd_pkg::DSD_R_NONE;
    if (a <= dsd_pkg::BANK_HI)
    begin
      if (bsel[dsd_pkg::BANK_RAM2_BIT] && !bsel[dsd_pkg::BANK_EE0_BIT])
        r = dsd_pkg::DSD_R_BRAM;
      else if (bsel[dsd_pkg::BANK_EE0_BIT] && !bsel[dsd_pkg::BANK_RAM2_BIT])
        r = dsd_pkg::DSD_R_EE;
    end
    else if (a <= dsd_pkg::WIN_HI)
      r = dsd_pkg::DSD_R_WIN;
    else if (a <= dsd_pkg::CORE_W || a == dsd_pkg::CORE_A)
      r = dsd_pkg::DSD_R_CORE;
    else if (a <= dsd_pkg::RAM_HI)
      r = dsd_pkg::DSD_R_RAM;
    else if ((a >= dsd_pkg::PDATA_LO && a <= dsd_pkg::PDATA_HI)
             || (a >= dsd_pkg::PDIR_LO && a <= dsd_pkg::PDIR_HI)
             || (a >= dsd_pkg::POPT_LO && a <= dsd_pkg::POPT_HI))
      r = dsd_pkg::DSD_R_PER;
    else if ((a >= dsd_pkg::PER_LO && a <= dsd_pkg::PER_HI) || a == dsd_pkg::EEPROM_CONTROL)
      r = dsd_pkg::DSD_R_PER;
    else if (a == dsd_pkg::INT_OPT)
      r = dsd_pkg::DSD_R_WO_EXT;
    else if (a == dsd_pkg::ROM_WINDOW_BASE)
      r = dsd_pkg::DSD_R_WBASE;
    else if (a == dsd_pkg::BANK_SELECT)
      r = dsd_pkg::DSD_R_BSEL;
    return r;
  endfunction

  function automatic logic [2:0] core_index(input logic [7:0] a);
    return (a == dsd_pkg::CORE_A) ? 3'h4 : {1'b0, a[1:0]};
  endfunction

  logic [7:0] bank_select_r;
  dsd_pkg::dsd_region_t region;
  logic rd_go;
  logic wr_go;
  logic [5:0] ram_idx;

  assign region = decode(cpu_addr, bank_select_r);
  assign rd_go = cpu_rd;
  assign wr_go = cpu_wr && !cpu_rd;
  assign ram_idx = 6'(cpu_addr - dsd_pkg::RAM_LO);

  // ****************************************************************
  // Window base block and bank select
  // ****************************************************************
  dsd_win_if win_bus (
    .clk(clk),
    .rst_n(rst_n_s)
  );

  assign win_bus.wr = wr_go && (region == dsd_pkg::DSD_R_WBASE);
  assign win_bus.wdata = cpu_wdata;
  assign win_bus.offset = cpu_addr[5:0];

  dsd_window u_window (
    .wb(win_bus.win)
  );

  // Kept without reset so the banked area stays unselected only by software.
  // bank not reset
  always_ff @(posedge clk)
  begin
    if (wr_go && region == dsd_pkg::DSD_R_BSEL)
    begin
      bank_select_r <= cpu_wdata;
    end
  end

  // ****************************************************************
  // Internal storage
  // ****************************************************************
  logic [7:0] ram [0:59];
  logic [7:0] bank_ram [0:63];
  logic [7:0] core_reg [0:4];
  logic [7:0] loc_data_r;

  always_ff @(posedge clk)
  begin
    if (wr_go && region == dsd_pkg::DSD_R_RAM)
      ram[ram_idx] <= cpu_wdata;
    if (wr_go && region == dsd_pkg::DSD_R_BRAM)
      bank_ram[cpu_addr[5:0]] <= cpu_wdata;
    if (wr_go && region == dsd_pkg::DSD_R_CORE)
      core_reg[core_index(cpu_addr)] <= cpu_wdata;
  end

  logic [7:0] loc_data_nxt;

  assign loc_data_nxt = (region == dsd_pkg::DSD_R_RAM) ? ram[ram_idx]
                      : (region == dsd_pkg::DSD_R_BRAM) ? bank_ram[cpu_addr[5:0]]
                      : (region == dsd_pkg::DSD_R_CORE) ? core_reg[core_index(cpu_addr)]
                      : dsd_pkg::RD_UNSPEC;

  always_ff @(posedge clk)
  begin
    loc_data_r <= loc_data_nxt;
  end

  // ****************************************************************
  // Access pipeline: strobes in cycle 1, read data in cycle 2
  // ****************************************************************
  dsd_pkg::dsd_region_t rd_region_r;
  logic rd_pend_r;
  logic ext_pend_r;
  logic ext_go;
  logic win_rd;
  logic [7:0] rd_mux;

  assign win_rd = rd_go && (region == dsd_pkg::DSD_R_WIN);
  // The core always has the program-memory port; an external read that
  // collides with a window read is dropped and must be repeated.
  assign ext_go = ext_rd && !win_rd;

  assign rd_mux = (rd_region_r == dsd_pkg::DSD_R_WIN) ? pmem_rdata
                : (rd_region_r == dsd_pkg::DSD_R_PER) ? per_rdata
                : (rd_region_r == dsd_pkg::DSD_R_EE) ? ee_rdata
                : loc_data_r;

  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      rd_region_r <= dsd_pkg::DSD_R_NONE;
      rd_pend_r <= 1'b0;
      ext_pend_r <= 1'b0;
      pmem_rd <= 1'b0;
      pmem_addr <= 12'h000;
      per_rd <= 1'b0;
      per_wr <= 1'b0;
      per_addr <= 8'h00;
      per_wdata <= 8'h00;
      ee_rd <= 1'b0;
      ee_wr <= 1'b0;
      ee_addr <= 6'h00;
      ee_wdata <= 8'h00;
      cpu_rvalid <= 1'b0;
      cpu_rdata <= 8'h00;
      ext_rvalid <= 1'b0;
      ext_rdata <= 8'h00;
    end
    else
    begin
      rd_region_r <= rd_go ? region : dsd_pkg::DSD_R_NONE;
      rd_pend_r <= rd_go;
      ext_pend_r <= ext_go;
      pmem_rd <= win_rd || ext_go;
      pmem_addr <= win_rd ? win_bus.pm_addr : ext_addr;
      per_rd <= rd_go && region == dsd_pkg::DSD_R_PER;
      per_wr <= wr_go && (region == dsd_pkg::DSD_R_PER || region == dsd_pkg::DSD_R_WO_EXT);
      per_addr <= cpu_addr;
      per_wdata <= cpu_wdata;
      ee_rd <= rd_go && region == dsd_pkg::DSD_R_EE;
      ee_wr <= wr_go && region == dsd_pkg::DSD_R_EE;
      ee_addr <= cpu_addr[5:0];
      ee_wdata <= cpu_wdata;
      cpu_rvalid <= rd_pend_r;
      cpu_rdata <= rd_pend_r ? rd_mux : 8'h00;
      ext_rvalid <= ext_pend_r;
      ext_rdata <= (ext_pend_r && !readout_protect) ? pmem_rdata : dsd_pkg::RD_UNSPEC;
    end
  end

  // ****************************************************************
  // Program counter and return stack
  // ****************************************************************
  logic [11:0] stk_top;
  logic stk_full;

  // A return that loses to a call or a jump must not pop, or the stack drifts from the counter.
  dsd_stack u_stack (
    .clk(clk),
    .rst_n(rst_n_s),
    .push(pc_call),
    .pop(pc_ret && !pc_call && !pc_jump),
    .push_data(12'(program_counter + 12'h001)),
    .top_data(stk_top),
    .full(stk_full),
    .depth()
  );

  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      program_counter <= 12'h000;
      stack_full <= 1'b0;
    end
    else
    begin
      stack_full <= stk_full;
      if (pc_call || pc_jump)
        program_counter <= pc_target;
      else if (pc_ret)
        program_counter <= stk_top;
      else if (pc_inc)
        program_counter <= program_counter + 12'h001;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_s);

  sequence s_win_read;
    rd_go && region == dsd_pkg::DSD_R_WIN;
  endsequence

  property p_win_addr;
    s_win_read |=> pmem_rd && pmem_addr == $past(win_bus.pm_addr);
  endproperty
  a_win_addr: assert property (p_win_addr) else $error("window address wrong");

  property p_win_data;
    s_win_read ##1 1'b1 |=> cpu_rvalid && cpu_rdata == $past(pmem_rdata);
  endproperty
  a_win_data: assert property (p_win_data) else $error("window data wrong");

  property p_wo_read;
    rd_go && (region == dsd_pkg::DSD_R_WBASE || region == dsd_pkg::DSD_R_BSEL
              || region == dsd_pkg::DSD_R_NONE) |-> ##2 cpu_rvalid && cpu_rdata == 8'h00;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only read leaked");

  property p_ee_route;
    rd_go && cpu_addr <= dsd_pkg::BANK_HI && bank_select_r == 8'h01
      |=> ee_rd && ee_addr == $past(cpu_addr[5:0]);
  endproperty
  a_ee_route: assert property (p_ee_route) else $error("EEPROM page not routed");

  property p_per_route;
    wr_go && (region == dsd_pkg::DSD_R_PER) |=> per_wr && per_addr == $past(cpu_addr)
      && per_wdata == $past(cpu_wdata);
  endproperty
  a_per_route: assert property (p_per_route) else $error("peripheral write lost");

  property p_protect;
    ext_go && readout_protect ##1 readout_protect |=> ext_rvalid && ext_rdata == 8'h00;
  endproperty
  a_protect: assert property (p_protect) else $error("protected data leaked");

  property p_pc_inc;
    pc_inc && !pc_jump && !pc_call && !pc_ret |=> program_counter == $past(program_counter) + 12'h001;
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("PC increment wrong");

endmodule // dsd_decoder

// [dsd_mem_model.sv]
// Far-side model of the decoder: program memory, peripheral registers and EEPROM page.
// Assumes the decoder strobes are one-cycle pulses and reads are answered in the strobe cycle.
`timescale 1ns/1ps
module dsd_mem_model (
  input wire logic clk,
  input wire logic [11:0] pmem_addr,
  input wire logic pmem_rd,
  output logic [7:0] pmem_rdata,
  input wire logic [7:0] per_addr,
  input wire logic per_rd,
  input wire logic per_wr,
  input wire logic [7:0] per_wdata,
  output logic [7:0] per_rdata,
  input wire logic [5:0] ee_addr,
  input wire logic ee_rd,
  input wire logic ee_wr,
  input wire logic [7:0] ee_wdata,
  output logic [7:0] ee_rdata,
  output int per_wr_cnt,
  output logic [7:0] per_last_addr
);
  logic [7:0] per_mem [256];
  logic [7:0] ee_mem [64];
  logic [7:0] pm_byte;

  // Content depends on every address bit, so a wrong base field shows.
  assign pm_byte = pmem_addr[7:0] ^ {4'h0, pmem_addr[11:8]};
  // Outside a read strobe the lines carry the inverse, never a stale match.
  assign pmem_rdata = pmem_rd ? pm_byte : ~pm_byte;
  assign per_rdata = per_rd ? per_mem[per_addr] : ~per_mem[per_addr];
  assign ee_rdata = ee_rd ? ee_mem[ee_addr] : ~ee_mem[ee_addr];

  initial
  begin
    per_wr_cnt = 0;
    per_last_addr = 8'h00;
    for (int i = 0; i < 256; i++)
      per_mem[i] = ~8'(i);
    for (int i = 0; i < 64; i++)
      ee_mem[i] = 8'(i) ^ 8'h3C;
  end

  always @(posedge clk)
  begin
    if (per_wr)
    begin
      per_mem[per_addr] <= per_wdata;
      per_wr_cnt <= per_wr_cnt + 1;
      per_last_addr <= per_addr;
    end
    if (ee_wr)
      ee_mem[ee_addr] <= ee_wdata;
  end
endmodule // dsd_mem_model

// [dsd_pkg.sv]
// Constants of the data-space decoder: address map, field positions, widths.
// Assumes an 8-bit data space, a 12-bit program space and byte-wide memories.
package dsd_pkg;

  localparam int DW = 8;
  localparam int PW = 12;
  localparam int WIN_OFS_W = 6;
  localparam int STACK_DEPTH = 6;
  localparam int STACK_CNT_W = 3;
  localparam int RAM_BYTES = 60;
  localparam int BANK_BYTES = 64;
  localparam int CORE_REGS = 5;

  localparam logic [7:0] BANK_LO = 8'h00;
  localparam logic [7:0] BANK_HI = 8'h3F;
  localparam logic [7:0] WIN_LO = 8'h40;
  localparam logic [7:0] WIN_HI = 8'h7F;
  localparam logic [7:0] CORE_X = 8'h80;
  localparam logic [7:0] CORE_W = 8'h83;
  localparam logic [7:0] RAM_LO = 8'h84;
  localparam logic [7:0] RAM_HI = 8'hBF;
  localparam logic [7:0] PDATA_LO = 8'hC0;
  localparam logic [7:0] PDATA_HI = 8'hC2;
  localparam logic [7:0] PDIR_LO = 8'hC4;
  localparam logic [7:0] PDIR_HI = 8'hC6;
  localparam logic [7:0] INT_OPT = 8'hC8;
  localparam logic [7:0] ROM_WINDOW_BASE = 8'hC9;
  localparam logic [7:0] POPT_LO = 8'hCC;
  localparam logic [7:0] POPT_HI = 8'hCE;
  localparam logic [7:0] PER_LO = 8'hD0;
  localparam logic [7:0] PER_HI = 8'hDB;
  localparam logic [7:0] BANK_SELECT = 8'hE8;
  localparam logic [7:0] EEPROM_CONTROL = 8'hEA;
  localparam logic [7:0] CORE_A = 8'hFF;

  localparam int BANK_RAM2_BIT = 4;
  localparam int BANK_EE0_BIT = 0;
  localparam logic [7:0] RD_UNSPEC = 8'h00;

  typedef enum logic [3:0] {
    DSD_R_NONE = 4'b0000,
    DSD_R_BRAM = 4'b0001,
    DSD_R_EE = 4'b0010,
    DSD_R_WIN = 4'b0011,
    DSD_R_CORE = 4'b0100,
    DSD_R_RAM = 4'b0101,
    DSD_R_PER = 4'b0110,
    DSD_R_WO_EXT = 4'b0111,
    DSD_R_WBASE = 4'b1000,
    DSD_R_BSEL = 4'b1001
  } dsd_region_t;

endpackage

// [dsd_stack.sv]
// Six-level return-address stack for calls and interrupt entry.
// Assumes push and pop are never requested together; push wins if they are.
`timescale 1ns/1ps
module dsd_stack (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [11:0] push_data,
  output logic [11:0] top_data,
  output logic full,
  output logic [2:0] depth
);

  logic [11:0] mem [0:5];
  logic [2:0] cnt_r;
  logic do_push;
  logic do_pop;

  // A push on a full stack is dropped, so the oldest return addresses survive.
  assign do_push = push && (cnt_r != 3'(dsd_pkg::STACK_DEPTH));
  assign do_pop = pop && !push && (cnt_r != 3'h0);
  assign full = (cnt_r == 3'(dsd_pkg::STACK_DEPTH));
  assign depth = cnt_r;
  assign top_data = (cnt_r == 3'h0) ? 12'h000 : mem[cnt_r - 3'h1];

  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      mem[cnt_r] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 3'h0;
    end
    else if (do_push)
    begin
      cnt_r <= cnt_r + 3'h1;
    end
    else if (do_pop)
    begin
      cnt_r <= cnt_r - 3'h1;
    end
  end

  property p_push_top;
    @(posedge clk) disable iff (!rst_n)
    do_push |=> (top_data == $past(push_data)) && (cnt_r == $past(cnt_r) + 3'h1);
  endproperty
  a_push_top: assert property (p_push_top) else $error("push lost");

endmodule // dsd_stack

// [dsd_win_if.sv]
// Link between the decoder and its window base register block.
// Assumes both ends share the system clock and the synchronised reset.
`timescale 1ns/1ps
interface dsd_win_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic wr;
  logic [7:0] wdata;
  logic [5:0] offset;
  logic [11:0] pm_addr;

  modport dec (input clk, input rst_n, output wr, output wdata, output offset, input pm_addr);
  modport win (input clk, input rst_n, input wr, input wdata, input offset, output pm_addr);
endinterface

// [dsd_window.sv]
// Window base register and program-memory address former.
// Assumes the decoder raises wr for one cycle per write to the base register.
`timescale 1ns/1ps
module dsd_window (
  dsd_win_if.win wb
);

  logic [5:0] window_base_bits_r;

  // The base is deliberately left without reset, as software must load it first.
  // no reset value
  always_ff @(posedge wb.clk)
  begin
    if (wb.wr)
    begin
      window_base_bits_r <= wb.wdata[5:0];
    end
  end

  assign wb.pm_addr = {window_base_bits_r, wb.offset};

  property p_base_steps;
    @(posedge wb.clk) disable iff (!wb.rst_n)
    wb.wr |=> (wb.pm_addr[11:6] == $past(wb.wdata[5:0])) && (wb.pm_addr[5:0] == wb.offset);
  endproperty
  a_base_steps: assert property (p_base_steps) else $error("window base not applied");

endmodule // dsd_window

// [tb_top.sv]
// Self-checking bench for the data-space decoder, acting as the CPU core.
// Assumes the far-side model answers program, peripheral and EEPROM reads at once.
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb_top;
  logic clk, rstn, cpu_rd, cpu_wr, cpu_rvalid, pmem_rd, per_rd, per_wr, ee_rd, ee_wr;
  logic readout_protect, ext_rd, ext_rvalid, pc_inc, pc_jump, pc_call, pc_ret, stack_full;
  logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, pmem_rdata, per_addr, per_wdata, per_rdata;
  logic [7:0] ee_wdata, ee_rdata, ext_rdata, per_last_addr, d;
  logic [11:0] pmem_addr, ext_addr, pc_target, program_counter;
  logic [11:0] stk [6];
  logic [5:0] ee_addr;
  logic [7:0] bases [4] = '{8'h00, 8'h3F, 8'h15, 8'hC5};
  logic [7:0] pers [10] = '{8'hC0, 8'hC2, 8'hC4, 8'hC6, 8'hCC, 8'hCE, 8'hD0, 8'hD8,
    8'hDB, 8'hEA};
  logic [7:0] cores [7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF, 8'h84, 8'hBF};
  int errors, tests_run, per_wr_cnt, cnt0;

  dsd_decoder dsd_decoder_inst (.clk(clk), .rstn(rstn), .cpu_addr(cpu_addr),
    .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_rvalid(cpu_rvalid), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
    .pmem_rdata(pmem_rdata), .per_addr(per_addr), .per_rd(per_rd), .per_wr(per_wr),
    .per_wdata(per_wdata), .per_rdata(per_rdata), .ee_addr(ee_addr), .ee_rd(ee_rd),
    .ee_wr(ee_wr), .ee_wdata(ee_wdata), .ee_rdata(ee_rdata),
    .readout_protect(readout_protect), .ext_rd(ext_rd), .ext_addr(ext_addr),
    .ext_rdata(ext_rdata), .ext_rvalid(ext_rvalid), .pc_inc(pc_inc), .pc_jump(pc_jump),
    .pc_call(pc_call), .pc_ret(pc_ret), .pc_target(pc_target),
    .program_counter(program_counter), .stack_full(stack_full));

  dsd_mem_model dsd_mem_model_inst (.clk(clk), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
    .pmem_rdata(pmem_rdata), .per_addr(per_addr), .per_rd(per_rd), .per_wr(per_wr),
    .per_wdata(per_wdata), .per_rdata(per_rdata), .ee_addr(ee_addr), .ee_rd(ee_rd),
    .ee_wr(ee_wr), .ee_wdata(ee_wdata), .ee_rdata(ee_rdata), .per_wr_cnt(per_wr_cnt),
    .per_last_addr(per_last_addr));

  // ************************************************************
  // Access tasks
  // ************************************************************
  function automatic logic [7:0] pm(input logic [11:0] a);
    return a[7:0] ^ {4'h0, a[11:8]};
  endfunction

  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cpu_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= v;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_wr <= 1'b0;
  endtask

  // Answer expected one edge after the taking edge; a few spare edges allowed.
  task automatic cpu_read(input logic [7:0] a, output logic [7:0] v);
    bit got;
    got = 0;
    @(posedge clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk);
    cpu_rd <= 1'b0;
    for (int n = 0; n < 5 && !got; n++)
    begin
      @(negedge clk);
      if (cpu_rvalid === 1'b1)
      begin
        v = cpu_rdata;
        got = 1;
      end
    end
    if (!got)
    begin
      errors++;
      report_and_stop();
    end
  endtask

  task automatic ext_read(input logic [11:0] a, output logic [7:0] v);
    bit got;
    got = 0;
    @(posedge clk);
    ext_addr <= a;
    ext_rd <= 1'b1;
    @(posedge clk);
    ext_rd <= 1'b0;
    for (int n = 0; n < 5 && !got; n++)
    begin
      @(negedge clk);
      if (ext_rvalid === 1'b1)
      begin
        v = ext_rdata;
        got = 1;
      end
    end
    if (!got)
    begin
      errors++;
      report_and_stop();
    end
  endtask

  // Command code: 0 increment, 1 jump, 2 call, 3 return.
  task automatic pc_cmd(input int c, input logic [11:0] t, input logic [11:0] exp);
    @(posedge clk);
    pc_inc <= (c == 0);
    pc_jump <= (c == 1);
    pc_call <= (c == 2);
    pc_ret <= (c == 3);
    pc_target <= t;
    @(posedge clk);
    {pc_inc, pc_jump, pc_call, pc_ret} <= 4'h0;
    @(negedge clk);
    `CHK("program_counter", exp, program_counter)
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    {rstn, cpu_rd, cpu_wr, ext_rd, readout_protect} = 5'h00;
    {pc_inc, pc_jump, pc_call, pc_ret} = 4'h0;
    cpu_addr = 8'h00;
    cpu_wdata = 8'h00;
    ext_addr = 12'h000;
    pc_target = 12'h000;
    errors = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("pc_after_reset", 12'h000, program_counter)
    // Window base is written before the first window read.
    for (int b = 0; b < 4; b++)
    begin
      cpu_write(8'hC9, bases[b]);
      foreach (cores[k])
      begin
        cpu_read(8'h40 + 8'((k * 9) & 63), d);
        `CHK("window", pm({bases[b][5:0], 6'((k * 9) & 63)}), d)
      end
      cpu_read(8'h7F, d);
      `CHK("window_top", pm({bases[b][5:0], 6'h3F}), d)
    end
    cpu_read(8'hC9, d);
    `CHK("base_read", 8'h00, d)
    foreach (cores[k])
      cpu_write(cores[k], 8'hA0 + 8'(k));
    foreach (cores[k])
    begin
      cpu_read(cores[k], d);
      `CHK("core_or_ram", 8'hA0 + 8'(k), d)
    end
    foreach (pers[k])
    begin
      cpu_write(pers[k], 8'h50 + 8'(k));
      cpu_read(pers[k], d);
      `CHK("periph", 8'h50 + 8'(k), d)
    end
    cnt0 = per_wr_cnt;
    cpu_write(8'hC3, 8'h77);
    cpu_write(8'hDD, 8'h77);
    repeat (2) @(posedge clk);
    `CHK("reserved_write_count", cnt0, per_wr_cnt)
    cpu_read(8'hC3, d);
    `CHK("reserved_read", 8'h00, d)
    cpu_write(8'hC8, 8'h3A);
    repeat (2) @(posedge clk);
    `CHK("int_opt_addr", 8'hC8, per_last_addr)
    cpu_read(8'hC8, d);
    `CHK("int_opt_read", 8'h00, d)
    // Bank select written before the banked region is used.
    cpu_write(8'hE8, 8'h10);
    cpu_write(8'h00, 8'hA5);
    cpu_write(8'h3F, 8'hC3);
    cpu_write(8'hE8, 8'h01);
    cpu_write(8'h00, 8'h5A);
    cpu_read(8'h00, d);
    `CHK("ee_page", 8'h5A, d)
    cpu_read(8'h3F, d);
    `CHK("ee_page_top", 8'h3F ^ 8'h3C, d)
    cpu_read(8'hE8, d);
    `CHK("bank_read", 8'h00, d)
    cpu_write(8'hE8, 8'h11);
    cpu_read(8'h00, d);
    `CHK("two_banks", 8'h00, d)
    cpu_write(8'hE8, 8'h00);
    cpu_write(8'h00, 8'hEE);
    cpu_read(8'h00, d);
    `CHK("no_bank", 8'h00, d)
    cpu_write(8'hE8, 8'h10);
    cpu_read(8'h00, d);
    `CHK("ram_page", 8'hA5, d)
    cpu_read(8'h3F, d);
    `CHK("ram_page_top", 8'hC3, d)
    // A shadow copy in RAM goes first, then the base itself.
    cpu_write(8'h90, 8'h2B);
    cpu_write(8'hC9, 8'h2B);
    cpu_read(8'h55, d);
    `CHK("window_after_shadow", pm({6'h2B, 6'h15}), d)
    ext_read(12'hABC, d);
    `CHK("readout_open", pm(12'hABC), d)
    @(posedge clk);
    readout_protect <= 1'b1;
    ext_read(12'hABC, d);
    `CHK("readout_blocked", 8'h00, d)
    pc_cmd(0, 12'h000, 12'h001);
    pc_cmd(1, 12'hFFF, 12'hFFF);
    pc_cmd(0, 12'h000, 12'h000);
    pc_cmd(1, 12'h123, 12'h123);
    stk[0] = 12'h124;
    for (int k = 0; k < 6; k++)
    begin
      pc_cmd(2, 12'h100 * 12'(k + 1), 12'h100 * 12'(k + 1));
      if (k < 5)
        stk[k + 1] = 12'h100 * 12'(k + 1) + 12'h001;
    end
    @(negedge clk);
    `CHK("stack_full", 1'b1, stack_full)
    pc_cmd(2, 12'hF00, 12'hF00);
    for (int k = 5; k >= 0; k--)
      pc_cmd(3, 12'h000, stk[k]);
    @(negedge clk);
    `CHK("stack_not_full", 1'b0, stack_full)
    // A return on an empty stack loads zero and ignores the target.
    pc_cmd(3, 12'hABC, 12'h000);
    report_and_stop();
  end
endmodule // tb_top
